// ### hdl/fpgp_port.v
// Five-pin general-purpose I/O port with Avalon-MM register slave
`include "fpgp_consts.vh"

// What this block does
// - Direction bit one makes a pin an output, zero an input.
// - An output pin drives the latched data bit.
// - Data writes always update the latch; pins show it only as outputs.
// - Reading an output pin's data bit returns the latch.
// - Input pins read live level; read-modify-write reads return latch.
// - An enabled peripheral output drives the pin instead of the latch.
// - Peripheral-driven pins read pin level; read-modify-write reads latch.
// - Input pins read pin level whether or not a peripheral uses them.
// - Reset clears all direction bits so pins start as inputs.
// - Isolating standby forces every pin to high impedance.
// - Isolating standby blocks inputs, forcing internal input low.
// - Clock-input pin stays open in standby when its interrupt is enabled.
// - Non-isolating standby keeps all pin states and levels unchanged.
// - Pull-up bit one connects the pull-up, zero leaves it off.
// - A pin driving low always has its pull-up disconnected.
// - Bits 0 to 4 map to pins 0 to 4; upper bits have none.
// - Pins 0,1 pulse gen; 2,3 timer outputs; 4 timer clock input.
module fpgp_port #(
  parameter PINS = 5
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire [`FPGP_ADDR_W-1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  input wire i_rmw_read,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire [PINS-1:0] i_pin_level,
  output reg [PINS-1:0] o_pin_out,
  output reg [PINS-1:0] o_pin_oe,
  output reg [PINS-1:0] o_pullup_en,
  output reg [PINS-1:0] o_input_value,
  input wire i_pulse_gen_ch0_out_a,
  input wire i_pulse_gen_ch0_out_a_oe,
  input wire i_pulse_gen_ch0_out_b,
  input wire i_pulse_gen_ch0_out_b_oe,
  input wire i_composite_timer_ch0_out_a,
  input wire i_composite_timer_ch0_out_a_oe,
  input wire i_composite_timer_ch0_out_b,
  input wire i_composite_timer_ch0_out_b_oe,
  output reg o_composite_timer_ch0_clock_in
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  reg [PINS-1:0] port_output_latch_q;
  reg [PINS-1:0] port_direction_select_q;
  reg [PINS-1:0] port_pullup_select_q;
  reg [3:0] standby_control_register_q;
  reg ack_q;

  wire [PINS-1:0] periph_val;
  wire [PINS-1:0] periph_oe;
  wire isolate;
  wire clkin_keep;
  reg [PINS-1:0] drv_val;
  reg [PINS-1:0] drv_oe;
  reg [PINS-1:0] in_open;
  reg [PINS-1:0] read_port;
  integer k;

  // Byte-lane merge; only lane 0 carries register bits
  function [7:0] fpgp_merge;
    input [7:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      fpgp_merge = be[0] ? wd[7:0] : old;
    end
  endfunction

  // Merged write bytes; upper bit positions masked, then cut on purpose
  wire [7:0] wr_latch;
  wire [7:0] wr_dir;
  wire [7:0] wr_pullup;
  wire [7:0] wr_standby;
  assign wr_latch = fpgp_merge({3'h0, port_output_latch_q},
    i_avs_writedata, i_avs_byteenable) & 8'h1f;
  assign wr_dir = fpgp_merge({3'h0, port_direction_select_q},
    i_avs_writedata, i_avs_byteenable) & 8'h1f;
  assign wr_pullup = fpgp_merge({3'h0, port_pullup_select_q},
    i_avs_writedata, i_avs_byteenable) & 8'h1f;
  assign wr_standby = fpgp_merge({4'h0, standby_control_register_q},
    i_avs_writedata, i_avs_byteenable) & 8'h0f;

  ////////////////////////////////////////////////////////////////////////
  // Peripheral sharing; pin 4 has no output function
  assign periph_val = {1'b0, i_composite_timer_ch0_out_b,
    i_composite_timer_ch0_out_a, i_pulse_gen_ch0_out_b,
    i_pulse_gen_ch0_out_a};
  assign periph_oe = {1'b0, i_composite_timer_ch0_out_b_oe,
    i_composite_timer_ch0_out_a_oe, i_pulse_gen_ch0_out_b_oe,
    i_pulse_gen_ch0_out_a_oe};

  // Isolation only when the select bit and stop/watch are both set
  assign isolate = standby_control_register_q[`FPGP_STB_SPL] &
    standby_control_register_q[`FPGP_STB_STOP];
  assign clkin_keep = standby_control_register_q[`FPGP_STB_EIC] &
    standby_control_register_q[`FPGP_STB_INTERRUPT_PIN_SELECT_CONTROL];

  ////////////////////////////////////////////////////////////////////////
  // Pin drive, input gating and read value per pin
  always @* begin
    drv_val = {PINS{1'b0}};
    drv_oe = {PINS{1'b0}};
    in_open = {PINS{1'b0}};
    read_port = {PINS{1'b0}};
    for (k = 0; k < PINS; k = k + 1) begin
      if (periph_oe[k]) begin
        drv_val[k] = periph_val[k];
        drv_oe[k] = 1'b1;
      end else begin
        drv_val[k] = port_output_latch_q[k];
        drv_oe[k] = port_direction_select_q[k];
      end
      if (isolate) begin
        drv_oe[k] = 1'b0;
      end
      in_open[k] = !isolate ||
        (k == `FPGP_CLKIN_PIN && clkin_keep);
      // Output pins read latch; inputs and peripheral pins read level
      if (i_rmw_read) begin
        read_port[k] = port_output_latch_q[k];
      end else if (port_direction_select_q[k] && !periph_oe[k]) begin
        read_port[k] = port_output_latch_q[k];
      end else begin
        read_port[k] = i_pin_level[k] & in_open[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin outputs registered; pull-up off while driving low
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pin_out <= {PINS{1'b0}};
      o_pin_oe <= {PINS{1'b0}};
      o_pullup_en <= {PINS{1'b0}};
      o_input_value <= {PINS{1'b0}};
      o_composite_timer_ch0_clock_in <= 1'b0;
    end else begin
      o_pin_out <= drv_val;
      o_pin_oe <= drv_oe;
      o_pullup_en <= port_pullup_select_q &
        ~(drv_oe & ~drv_val);
      o_input_value <= i_pin_level & in_open;
      o_composite_timer_ch0_clock_in <=
        i_pin_level[`FPGP_CLKIN_PIN] & in_open[`FPGP_CLKIN_PIN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, answer on the second edge
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_q);
    end
  end

  // Register writes land only at the accepting edge
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      port_output_latch_q <= `FPGP_RST_LATCH;
      port_direction_select_q <= `FPGP_RST_DIR;
      port_pullup_select_q <= `FPGP_RST_PULLUP;
      standby_control_register_q <= `FPGP_RST_STANDBY;
    end else if (i_avs_write && ack_q) begin
      case (i_avs_address)
        `FPGP_OFF_LATCH: port_output_latch_q <= wr_latch[PINS-1:0];
        `FPGP_OFF_DIR: port_direction_select_q <= wr_dir[PINS-1:0];
        `FPGP_OFF_PULLUP: port_pullup_select_q <= wr_pullup[PINS-1:0];
        `FPGP_OFF_STANDBY: standby_control_register_q <= wr_standby[3:0];
        default: port_output_latch_q <= port_output_latch_q;
      endcase
    end
  end

  // Read data; upper bits and unmapped addresses read zero
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      case (i_avs_address)
        `FPGP_OFF_LATCH: o_avs_readdata <= {27'h0, read_port};
        `FPGP_OFF_DIR: o_avs_readdata <= {27'h0, port_direction_select_q};
        `FPGP_OFF_PULLUP: o_avs_readdata <= {27'h0, port_pullup_select_q};
        `FPGP_OFF_STANDBY:
          o_avs_readdata <= {28'h0, standby_control_register_q};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### hdl/fpgp_consts.vh
// Register offsets, reset values and field positions for the GPIO port
`ifndef FPGP_CONSTS_VH
`define FPGP_CONSTS_VH
`define FPGP_ADDR_W 2
`define FPGP_OFF_LATCH 2'h0
`define FPGP_OFF_DIR 2'h1
`define FPGP_OFF_PULLUP 2'h2
`define FPGP_OFF_STANDBY 2'h3
`define FPGP_RST_LATCH 5'h00
`define FPGP_RST_DIR 5'h00
`define FPGP_RST_PULLUP 5'h00
`define FPGP_RST_STANDBY 4'h0
`define FPGP_STB_SPL 0
`define FPGP_STB_STOP 1
`define FPGP_STB_EIC 2
`define FPGP_STB_INTERRUPT_PIN_SELECT_CONTROL 3
`define FPGP_CLKIN_PIN 4
`endif

// ### tb/fpgp_pads.sv
// Board pad model for the five port pins
module fpgp_pads (
  input wire i_clock,
  input wire [4:0] i_out, i_oe, i_pu, i_ext, i_ext_en,
  output logic [4:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] wander_q = 5'h0a;
  // Floating pads toggle so a stale level never passes
  always @(posedge i_clock) wander_q <= ~wander_q;
  // Device drive wins, then board drive, then pull-up
  always_comb
    for (int i = 0; i < 5; i++)
      o_level[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext[i] :
        i_pu[i] ? 1'b1 : wander_q[i];
endmodule

// ### tb/fpgp_port_monitor.sv
// Port-level checker for the GPIO block
module fpgp_port_monitor (
  input wire i_clock, i_rst_n, i_avs_read, i_avs_write, i_rmw_read,
  input wire [1:0] i_avs_address,
  input wire [31:0] i_avs_writedata, o_avs_readdata,
  input wire o_avs_waitrequest, o_composite_timer_ch0_clock_in,
  input wire [4:0] i_pin_level, o_pin_out, o_pin_oe, o_pullup_en,
  input wire [4:0] o_input_value,
  input wire i_pulse_gen_ch0_out_a, i_pulse_gen_ch0_out_a_oe,
  input wire i_pulse_gen_ch0_out_b, i_pulse_gen_ch0_out_b_oe,
  input wire i_composite_timer_ch0_out_a, i_composite_timer_ch0_out_a_oe,
  input wire i_composite_timer_ch0_out_b, i_composite_timer_ch0_out_b_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [4:0] lat_q, dir_q;
  reg [3:0] stb_q;
  wire [4:0] pe = {1'b0, i_composite_timer_ch0_out_b_oe,
    i_composite_timer_ch0_out_a_oe, i_pulse_gen_ch0_out_b_oe,
    i_pulse_gen_ch0_out_a_oe};
  wire [4:0] pv = {1'b0, i_composite_timer_ch0_out_b,
    i_composite_timer_ch0_out_a, i_pulse_gen_ch0_out_b,
    i_pulse_gen_ch0_out_a};
  wire iso = stb_q[0] & stb_q[1];
  wire run = i_rst_n & !stb_q[1];
  wire [4:0] lo = dir_q & ~pe;
  wire [4:0] rx = i_rmw_read ? lat_q : (lo & lat_q) | (~lo & i_pin_level);
  wire acc = !o_avs_waitrequest & (i_avs_read | i_avs_write);
  ////////////////////
  // Shadow registers; stop mode is left out of the enable, drive and input checks
  always @(posedge i_clock)
    if (!i_rst_n) begin
      lat_q <= 5'h00;
      dir_q <= 5'h00;
      stb_q <= 4'h0;
    end else if (acc & i_avs_write)
      case (i_avs_address)
        2'h0: lat_q <= i_avs_writedata[4:0];
        2'h1: dir_q <= i_avs_writedata[4:0];
        2'h3: stb_q <= i_avs_writedata[3:0];
        default: ;
      endcase
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_wait;
    o_avs_waitrequest & (i_avs_read | i_avs_write) |=>
      !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  property p_rst;
    $rose(i_rst_n) |-> o_pin_oe == 5'h00 && o_avs_waitrequest;
  endproperty
  property p_oe;
    $past(run) |-> o_pin_oe == $past(pe | dir_q);
  endproperty
  property p_out;
    $past(run) |->
      (o_pin_out & o_pin_oe) == ($past(pe & pv | ~pe & lat_q) & o_pin_oe);
  endproperty
  property p_pull;
    (o_pullup_en & o_pin_oe & ~o_pin_out) == 5'h00;
  endproperty
  property p_iso;
    $past(i_rst_n & iso) |-> o_pin_oe == 5'h00 && o_input_value[3:0] == 4'h0;
  endproperty
  property p_clk;
    $past(i_rst_n) |-> o_composite_timer_ch0_clock_in ==
      $past(i_pin_level[4] & (!iso | stb_q[2] & stb_q[3]));
  endproperty
  property p_in;
    $past(run) |-> o_input_value == $past(i_pin_level);
  endproperty
  property p_rd;
    i_avs_read & o_avs_waitrequest & i_avs_address == 2'h0 & !stb_q[1] |=>
      o_avs_readdata[7:0] == {3'h0, $past(rx)};
  endproperty
  a_wait: assert property (p_wait) else $error("bad wait");
  a_rst: assert property (p_rst) else $error("bad reset");
  a_oe: assert property (p_oe) else $error("bad enable");
  a_out: assert property (p_out) else $error("bad drive");
  a_pull: assert property (p_pull) else $error("bad pullup");
  a_iso: assert property (p_iso) else $error("bad isolation");
  a_clk: assert property (p_clk) else $error("bad clock in");
  a_in: assert property (p_in) else $error("bad input");
  a_rd: assert property (p_rd) else $error("bad read");
  c_rmw: cover property (acc & i_avs_read & i_rmw_read);
  c_wake: cover property (iso & stb_q[2] & stb_q[3]);
  c_per: cover property (acc & i_avs_read & pe != 5'h00);
endmodule
bind fpgp_port fpgp_port_monitor mon_u (.*);

// ### tb/fpgp_port_bench.sv
// Self-checking bench for the GPIO port
module fpgp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 0, i_rst_n = 0, i_avs_read = 0, i_avs_write = 0;
  logic i_rmw_read = 0;
  logic [1:0] i_avs_address = 2'h0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
  logic [3:0] i_avs_byteenable = 4'h1;
  logic [4:0] pv = 5'h00, pe = 5'h00, ext = 5'h00, ext_en = 5'h00;
  logic o_avs_waitrequest, o_composite_timer_ch0_clock_in;
  logic [4:0] i_pin_level, o_pin_out, o_pin_oe, o_pullup_en, o_input_value;
  logic [7:0] rd;
  int n_errors = 0, samples_checked = 0;
  wire i_pulse_gen_ch0_out_a = pv[0], i_pulse_gen_ch0_out_b = pv[1];
  wire i_composite_timer_ch0_out_a = pv[2], i_composite_timer_ch0_out_b = pv[3];
  wire i_pulse_gen_ch0_out_a_oe = pe[0], i_pulse_gen_ch0_out_b_oe = pe[1];
  wire i_composite_timer_ch0_out_a_oe = pe[2];
  wire i_composite_timer_ch0_out_b_oe = pe[3];
  fpgp_port dut_u (.*);
  fpgp_pads pads_u (.i_clock(i_clock), .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_pu(o_pullup_en), .i_ext(ext), .i_ext_en(ext_en), .o_level(i_pin_level));
  always #2 i_clock = ~i_clock;
  ////////////////////
  task test_done;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus transfer; a gap edge first, so no signal is set twice
  task xfer(input logic w, input logic [1:0] a, input logic [7:0] d,
    input logic m);
    @(posedge i_clock);
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_rmw_read <= m;
    do @(posedge i_clock); while (o_avs_waitrequest);
    rd = o_avs_readdata[7:0];
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  // Pins lag the register write by one edge
  task settle;
    repeat (3) @(posedge i_clock);
  endtask
  ////////////////////
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      xfer(0, a[1:0], 8'h00, 1);
      chk("reset", rd, 8'h00);
    end
    ext_en <= 5'h1f;
    ext <= 5'h0a;
    xfer(1, 2'h0, 8'hf5, 0);
    settle;
    chk("oe", 8'(o_pin_oe), 8'h00);
    xfer(0, 2'h0, 8'h00, 0);
    chk("read", rd, 8'h0a);
    xfer(0, 2'h0, 8'h00, 1);
    chk("rmw", rd, 8'h15);
    $display("t1 end");
    ext_en <= 5'h00;
    xfer(1, 2'h1, 8'h1f, 0);
    xfer(1, 2'h2, 8'h1f, 0);
    settle;
    chk("out", 8'(o_pin_out), 8'h15);
    chk("pull", 8'(o_pullup_en), 8'h15);
    xfer(0, 2'h0, 8'h00, 0);
    chk("read", rd, 8'h15);
    xfer(0, 2'h1, 8'h00, 0);
    chk("dir", rd, 8'h1f);
    pv <= 5'h0a;
    pe <= 5'h0f;
    xfer(1, 2'h1, 8'h00, 0);
    settle;
    chk("oe", 8'(o_pin_oe), 8'h0f);
    xfer(0, 2'h0, 8'h00, 0);
    chk("read", rd, 8'h1a);
    xfer(0, 2'h0, 8'h00, 1);
    chk("rmw", rd, 8'h15);
    $display("t2 end");
    pe <= 5'h00;
    xfer(1, 2'h1, 8'h1f, 0);
    xfer(1, 2'h3, 8'h02, 0);
    settle;
    chk("oe", 8'(o_pin_oe), 8'h1f);
    ext_en <= 5'h1f;
    ext <= 5'h1f;
    xfer(1, 2'h3, 8'h03, 0);
    settle;
    chk("oe", 8'(o_pin_oe), 8'h00);
    chk("in", 8'(o_input_value), 8'h00);
    xfer(1, 2'h1, 8'h0f, 0);
    xfer(1, 2'h3, 8'h0f, 0);
    settle;
    xfer(0, 2'h3, 8'h00, 0);
    chk("stb", rd, 8'h0f);
    chk("clk", 8'(o_composite_timer_ch0_clock_in), 8'h01);
    $display("t3 end");
    test_done;
  end
  // Watchdog well past the expected run
  initial begin
    repeat (2000) @(posedge i_clock);
    n_errors++;
    test_done;
  end
endmodule
